/* rtl/mgmt_pkg.sv */
package mgmt_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_HZ = 40_000_000;
	localparam int INIT_TIME_MS = 2000;
	localparam int INIT_CYCLES_DFLT = INIT_TIME_MS * (SYS_CLK_HZ / 1000);
	localparam int INIT_CNT_W = 27;
	localparam int RESET_MIN_US = 2;
	localparam int RESET_MIN_CYCLES = (RESET_MIN_US * SYS_CLK_HZ + 999_999) / 1_000_000;
	localparam int RST_CNT_W = 7;

	// ----------------------------------------------------------------
	// Management byte map
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h50;
	localparam logic [7:0] REG_ID = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h02;
	localparam logic [7:0] REG_FLAGS = 8'h03;
	localparam logic [7:0] REG_CTRL = 8'h5D;
	localparam logic [7:0] REG_MASK = 8'h64;
	localparam int DNR_BIT = 0;
	localparam int INIT_IRQ_BIT = 1;
	localparam int PDOWN_BIT = 1;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BUS_IDLE = 3'b000,
		BUS_RX = 3'b001,
		BUS_RX_ACK = 3'b011,
		BUS_TX = 3'b010,
		BUS_TX_ACK = 3'b110
	} bus_state_e;

	typedef enum logic [1:0] {
		KIND_DEV = 2'b00,
		KIND_PTR = 2'b01,
		KIND_DATA = 2'b11
	} byte_kind_e;

	typedef struct packed {
		logic [3:0] fault;
		logic [3:0] los;
	} cond_s;

	typedef struct packed {
		cond_s cond;
		logic txdis;
		logic lp;
		logic rst_n;
		logic sel_n;
		logic sda;
		logic scl;
	} pins_s;

	typedef struct packed {
		pins_s meta;
		pins_s sync;
		logic scl_prev;
		logic sda_prev;
		cond_s cond_prev;
		logic [RST_CNT_W-1:0] rst_low_cnt;
		logic in_reset;
		logic [INIT_CNT_W-1:0] init_cnt;
		logic ready;
		logic init_irq;
		logic [7:0] flags;
		logic [7:0] mask;
		logic [7:0] ctrl;
		logic [7:0] mask_stage;
		logic [7:0] ctrl_stage;
		logic [7:0] clr_flags;
		logic wr_mask_pend;
		logic wr_ctrl_pend;
		logic clr_init;
		bus_state_e bst;
		byte_kind_e kind;
		logic [3:0] cnt;
		logic [7:0] shreg;
		logic [7:0] ptr;
		logic rw;
		logic nack;
		logic sda_oe;
		logic irq_n;
		logic lp_act;
		logic laser_en;
	} mgmt_s;

endpackage : mgmt_pkg

/* rtl/module_mgmt_control_timing.sv */
// Functional notes
// - Fully functional within 2000 ms of start
// - Reset pin low must exceed 2 us
// - Serial bus answers within 2000 ms
// - Clear data-not-ready and assert interrupt, 2000 ms
// - Reset release to functional within 2000 ms
// - Functional means interrupt from data-ready
// - Low-power pin enters low power within 100 us
// - Interrupt asserts within 200 ms of condition
// - Clear-on-read releases interrupt within 500 us
// - Loss-of-signal flag and interrupt within 100 ms
// - Other flags and interrupt within 200 ms
// - Set mask inhibits interrupt within 100 ms
// - Cleared mask restores interrupt within 100 ms
// - Select asserted: answer bus within 100 us
// - Select released: stop answering within 100 us
// - Power-down bit enters low power, 100 ms
// - Power-down cleared: functional within 300 ms
// - Write timing counts from stop condition
// - Transmit-disable high or open disables laser
`timescale 1ns/10ps
module module_mgmt_control_timing
	import mgmt_pkg::*;
#(
	parameter int INIT_CYCLES = mgmt_pkg::INIT_CYCLES_DFLT,
	parameter logic [7:0] ID_VALUE = 8'h00 // arbitrary identifier value
)
(
	input wire logic sys_clk, // 40 MHz clock
	input wire logic rst_n, // power-on reset
	input wire logic scl_in, // serial clock from host
	input wire logic sda_in, // serial data wire level
	output logic sda_out, // serial data drive value
	output logic sda_oe, // pulls serial data low when high
	input wire logic module_select_n, // host selects module
	input wire logic module_reset_n, // host reset pin
	input wire logic low_power_request, // host low-power pin
	input wire logic transmit_disable_in, // laser disable pin
	input wire mgmt_pkg::cond_s cond_in, // raw loss and fault conditions
	output logic interrupt_out_n, // interrupt to host
	output logic module_present_n, // presence indication
	output logic low_power_active, // low power level in force
	output logic laser_enable, // laser output on
	output logic module_ready // fully functional
);
	import mgmt_pkg::*;

	mgmt_s s_reg;
	mgmt_s s_next;
	pins_s pins;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [7:0] cond_rise;

	// ----------------------------------------------------------------
	// Byte read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_byte(input mgmt_s s);
		logic [7:0] b;
		b = 8'h00;
		case (s.ptr)
			REG_ID: b = ID_VALUE;
			REG_STATUS:
			begin
				b[DNR_BIT] = ~s.ready;
				b[INIT_IRQ_BIT] = s.init_irq;
			end
			REG_FLAGS: b = s.flags;
			REG_MASK: b = s.mask;
			REG_CTRL: b = s.ctrl;
			default: b = 8'h00;
		endcase
		return b;
	endfunction : read_byte

	// ----------------------------------------------------------------
	// Pin sampling and bus events
	// ----------------------------------------------------------------
	assign pins = '{cond: cond_in, txdis: transmit_disable_in, lp: low_power_request,
		rst_n: module_reset_n, sel_n: module_select_n, sda: sda_in, scl: scl_in};
	assign scl_rise = s_reg.sync.scl & ~s_reg.scl_prev;
	assign scl_fall = ~s_reg.sync.scl & s_reg.scl_prev;
	assign start_c = s_reg.sync.scl & s_reg.scl_prev & s_reg.sda_prev & ~s_reg.sync.sda;
	assign stop_c = s_reg.sync.scl & s_reg.scl_prev & ~s_reg.sda_prev & s_reg.sync.sda;
	assign cond_rise = s_reg.sync.cond & ~s_reg.cond_prev;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic load;
		logic [7:0] clr;
		logic [7:0] tx;
		load = 1'b0;
		clr = 8'h00;
		tx = 8'h00;
		s_next = s_reg;
		s_next.meta = pins;
		s_next.sync = s_reg.meta;
		s_next.scl_prev = s_reg.sync.scl;
		s_next.sda_prev = s_reg.sync.sda;
		s_next.cond_prev = s_reg.sync.cond;

		// Short glitches on the reset pin are ignored
		if (s_reg.sync.rst_n)
		begin
			s_next.rst_low_cnt = '0;
			s_next.in_reset = 1'b0;
		end
		else if (s_reg.rst_low_cnt == RST_CNT_W'(RESET_MIN_CYCLES))
			s_next.in_reset = 1'b1;
		else
			s_next.rst_low_cnt = s_reg.rst_low_cnt + 1'b1;

		// Initialisation ends by raising the ready interrupt
		if (!s_reg.ready)
		begin
			if (s_reg.init_cnt == INIT_CNT_W'(INIT_CYCLES - 1))
			begin
				s_next.ready = 1'b1;
				s_next.init_irq = 1'b1;
			end
			else
				s_next.init_cnt = s_reg.init_cnt + 1'b1;
		end

		// Stop commits staged writes and read clears; set wins over clear
		if (stop_c)
		begin
			clr = s_reg.clr_flags;
			if (s_reg.wr_mask_pend)
				s_next.mask = s_reg.mask_stage;
			if (s_reg.wr_ctrl_pend)
				s_next.ctrl = s_reg.ctrl_stage;
			if (s_reg.clr_init && s_reg.ready)
				s_next.init_irq = 1'b0;
			s_next.wr_mask_pend = 1'b0;
			s_next.wr_ctrl_pend = 1'b0;
			s_next.clr_init = 1'b0;
			s_next.clr_flags = 8'h00;
		end
		s_next.flags = (s_reg.flags & ~clr) | cond_rise;

		// Two-wire slave
		if (stop_c)
		begin
			s_next.bst = BUS_IDLE;
			s_next.sda_oe = 1'b0;
		end
		else if (start_c)
		begin
			s_next.sda_oe = 1'b0;
			s_next.cnt = 4'h0;
			s_next.kind = KIND_DEV;
			s_next.bst = (!s_reg.sync.sel_n && !s_reg.in_reset) ? BUS_RX : BUS_IDLE;
		end
		else if (s_reg.sync.sel_n)
		begin
			// Deselect drops the transfer and whatever it staged
			s_next.bst = BUS_IDLE;
			s_next.sda_oe = 1'b0;
			s_next.wr_mask_pend = 1'b0;
			s_next.wr_ctrl_pend = 1'b0;
			s_next.clr_init = 1'b0;
			s_next.clr_flags = 8'h00;
		end
		else
		begin
			case (s_reg.bst)
				BUS_IDLE: s_next.bst = BUS_IDLE;
				BUS_RX:
				begin
					if (scl_rise)
					begin
						s_next.shreg = {s_reg.shreg[6:0], s_reg.sync.sda};
						s_next.cnt = s_reg.cnt + 1'b1;
					end
					else if (scl_fall && s_reg.cnt == 4'h8)
					begin
						s_next.cnt = 4'h0;
						if (s_reg.kind == KIND_DEV && s_reg.shreg[7:1] != DEV_ADDR)
							s_next.bst = BUS_IDLE;
						else
						begin
							s_next.bst = BUS_RX_ACK;
							s_next.sda_oe = 1'b1;
							if (s_reg.kind == KIND_DEV)
								s_next.rw = s_reg.shreg[0];
							else if (s_reg.kind == KIND_PTR)
								s_next.ptr = s_reg.shreg;
							else
							begin
								if (s_reg.ptr == REG_MASK)
								begin
									s_next.mask_stage = s_reg.shreg;
									s_next.wr_mask_pend = 1'b1;
								end
								if (s_reg.ptr == REG_CTRL)
								begin
									s_next.ctrl_stage = s_reg.shreg;
									s_next.wr_ctrl_pend = 1'b1;
								end
								s_next.ptr = s_reg.ptr + 1'b1;
							end
						end
					end
				end
				BUS_RX_ACK:
				begin
					if (scl_fall)
					begin
						s_next.sda_oe = 1'b0;
						if (s_reg.kind == KIND_DEV && s_reg.rw)
							load = 1'b1;
						else
						begin
							s_next.kind = (s_reg.kind == KIND_DEV) ? KIND_PTR : KIND_DATA;
							s_next.bst = BUS_RX;
						end
					end
				end
				BUS_TX:
				begin
					if (scl_fall)
					begin
						if (s_reg.cnt == 4'h8)
						begin
							s_next.sda_oe = 1'b0;
							s_next.bst = BUS_TX_ACK;
						end
						else
						begin
							s_next.shreg = {s_reg.shreg[6:0], 1'b0};
							s_next.sda_oe = ~s_reg.shreg[6];
							s_next.cnt = s_reg.cnt + 1'b1;
						end
					end
				end
				BUS_TX_ACK:
				begin
					if (scl_rise)
						s_next.nack = s_reg.sync.sda;
					else if (scl_fall)
					begin
						if (s_reg.nack)
							s_next.bst = BUS_IDLE;
						else
							load = 1'b1;
					end
				end
				default: s_next.bst = BUS_IDLE;
			endcase
		end

		// Read byte goes out MSB first; flag bits and the init interrupt that were read are cleared at stop
		if (load)
		begin
			tx = read_byte(s_reg);
			s_next.bst = BUS_TX;
			s_next.shreg = tx;
			s_next.sda_oe = ~tx[7];
			s_next.cnt = 4'h1;
			s_next.ptr = s_reg.ptr + 1'b1;
			if (s_reg.ptr == REG_FLAGS)
				s_next.clr_flags = s_reg.clr_flags | tx;
			if (s_reg.ptr == REG_STATUS && tx[INIT_IRQ_BIT])
				s_next.clr_init = 1'b1;
		end

		// Held reset wipes the management state and restarts initialisation
		if (s_reg.in_reset)
		begin
			s_next.ready = 1'b0;
			s_next.init_cnt = '0;
			s_next.init_irq = 1'b0;
			s_next.flags = 8'h00;
			s_next.mask = 8'h00;
			s_next.ctrl = 8'h00;
			s_next.wr_mask_pend = 1'b0;
			s_next.wr_ctrl_pend = 1'b0;
			s_next.clr_init = 1'b0;
			s_next.clr_flags = 8'h00;
			s_next.bst = BUS_IDLE;
			s_next.sda_oe = 1'b0;
		end

		// Registered pin outputs
		s_next.irq_n = ~(s_reg.init_irq | (|(s_reg.flags & ~s_reg.mask)));
		s_next.lp_act = s_reg.sync.lp | s_reg.ctrl[PDOWN_BIT];
		s_next.laser_en = ~s_reg.sync.txdis;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_reg <= '0;
			s_reg.irq_n <= 1'b1;
			// Laser stays off until the disable pin has really been sampled
			s_reg.meta.txdis <= 1'b1;
			s_reg.sync.txdis <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	assign sda_out = 1'b0;
	assign sda_oe = s_reg.sda_oe;
	assign interrupt_out_n = s_reg.irq_n;
	assign module_present_n = 1'b0;
	assign low_power_active = s_reg.lp_act;
	assign laser_enable = s_reg.laser_en;
	assign module_ready = s_reg.ready;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	irq_assert_a: assert property ((|(cond_rise & ~s_reg.mask)) && !s_reg.in_reset
		|-> ##[1:3] !interrupt_out_n)
		else $error("interrupt not asserted after condition");
	flag_latch_a: assert property (!stop_c && !s_reg.in_reset
		|=> (s_reg.flags & $past(s_reg.flags)) == $past(s_reg.flags))
		else $error("flag lost before read");
	irq_release_a: assert property (stop_c && s_reg.ready && !s_reg.wr_mask_pend
		&& cond_rise == 8'h00 && !s_reg.in_reset && (!s_reg.init_irq || s_reg.clr_init)
		&& (s_reg.flags & ~s_reg.clr_flags & ~s_reg.mask) == 8'h00
		|-> ##2 interrupt_out_n)
		else $error("interrupt not released after clearing read");
	mask_gate_a: assert property (!s_reg.init_irq && (s_reg.flags & ~s_reg.mask) == 8'h00
		|=> interrupt_out_n)
		else $error("masked flag drives interrupt");
	mask_pass_a: assert property ((|(s_reg.flags & ~s_reg.mask)) |=> !interrupt_out_n)
		else $error("unmasked flag ignored");
	init_done_a: assert property ($rose(s_reg.ready) |-> s_reg.init_irq
		##1 !interrupt_out_n)
		else $error("ready without interrupt");
	reset_filter_a: assert property ($rose(s_reg.in_reset)
		|-> $past(s_reg.rst_low_cnt) == RST_CNT_W'(RESET_MIN_CYCLES) && !$past(s_reg.sync.rst_n))
		else $error("reset taken from short pulse");
	deselect_a: assert property (s_reg.sync.sel_n |=> !sda_oe)
		else $error("bus driven while deselected");
	laser_off_a: assert property (s_reg.sync.txdis |=> !laser_enable)
		else $error("laser on while disabled");
	write_commit_a: assert property (stop_c && s_reg.wr_ctrl_pend && !s_reg.in_reset
		|=> s_reg.ctrl == $past(s_reg.ctrl_stage) ##1 low_power_active == s_reg.ctrl[PDOWN_BIT]
		|| s_reg.sync.lp)
		else $error("control write not applied at stop");
	present_a: assert property (!module_present_n)
		else $error("presence released");

	init_cov_c: cover property ($rose(module_ready));
	read_clear_c: cover property (stop_c && s_reg.clr_flags != 8'h00);
	mask_write_c: cover property (stop_c && s_reg.wr_mask_pend);
	select_ack_c: cover property (s_reg.bst == BUS_RX_ACK && s_reg.kind == KIND_DEV);

endmodule : module_mgmt_control_timing

/* verif/host_master.sv */
`timescale 1ns/10ps
module host_master
(
	output logic scl, // serial clock, idles high
	output logic sda_low, // host pulls data low
	input wire logic sda // resolved data wire
);
	import mgmt_pkg::*;

	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ----------------------------------------------------------------
	// Bit level
	// ----------------------------------------------------------------
	// Low 150 ns, high 50 ns: the module moves its data within three clocks (75 ns) of a fall
	task automatic bit_cyc(input logic v, output logic s);
	begin
		#50 sda_low = ~v;
		#100 scl = 1'b1;
		#40 s = sda;
		#10 scl = 1'b0;
	end
	endtask : bit_cyc

	task automatic start;
	begin
		// SCL stays low long enough for the module to let go of SDA first
		sda_low = 1'b0;
		#150 scl = 1'b1;
		#50 sda_low = 1'b1;
		#50 scl = 1'b0;
	end
	endtask : start

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
	begin
		for (int i = 7; i >= 0; i--)
			bit_cyc(d[i], s);
		bit_cyc(1'b1, s);
		ack = ~s;
	end
	endtask : wr_byte

	// ----------------------------------------------------------------
	// One register access, single byte
	// ----------------------------------------------------------------
	task automatic xfer(input logic [7:0] ptr, input logic rd_op, input logic [7:0] wd,
		output logic [7:0] rd, output logic ack);
		logic a1, a2, a3, s;
	begin
		#7;
		start();
		wr_byte({DEV_ADDR, 1'b0}, a1);
		wr_byte(ptr, a2);
		rd = 8'h00;
		if (rd_op)
		begin
			start();
			wr_byte({DEV_ADDR, 1'b1}, a3);
			for (int i = 7; i >= 0; i--)
			begin
				bit_cyc(1'b1, s);
				rd[i] = s;
			end
			bit_cyc(1'b1, s);
		end
		else
			wr_byte(wd, a3);
		sda_low = 1'b1;
		#50 scl = 1'b1;
		#50 sda_low = 1'b0;
		#100;
		ack = a1 & a2 & a3;
	end
	endtask : xfer
endmodule : host_master

/* verif/module_mgmt_control_timing_tb.sv */
`timescale 1ns/10ps
module module_mgmt_control_timing_tb;
	import mgmt_pkg::*;
	localparam int INIT_N = 200;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, sda_low, sda, sda_out, sda_oe;
	logic module_select_n = 1'b0;
	logic module_reset_n = 1'b1;
	logic low_power_request = 1'b0;
	logic transmit_disable_in = 1'b1;
	cond_s cond_in = '0;
	logic interrupt_out_n, module_present_n, low_power_active, laser_enable, module_ready;
	int err_total = 0;
	int checked = 0;
	logic ack;
	logic [7:0] rd;

	always #12.5 sys_clk = ~sys_clk;
	// Open drain with pull-up
	assign sda = ~((sda_oe & ~sda_out) | sda_low);

	module_mgmt_control_timing #(.INIT_CYCLES(INIT_N)) i_module_mgmt_control_timing (
		.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .module_select_n(module_select_n),
		.module_reset_n(module_reset_n), .low_power_request(low_power_request),
		.transmit_disable_in(transmit_disable_in), .cond_in(cond_in),
		.interrupt_out_n(interrupt_out_n), .module_present_n(module_present_n),
		.low_power_active(low_power_active), .laser_enable(laser_enable),
		.module_ready(module_ready));

	host_master i_host_master (.scl(scl), .sda_low(sda_low), .sda(sda));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
	begin
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %0t %s: got %h want %h", $time, msg, seen, exp);
		end
	end
	endtask : check

	task automatic tick(input int n);
	begin
		repeat (n) @(posedge sys_clk);
		#2;
	end
	endtask : tick

	task automatic wait_irq(input logic v);
	begin
		for (int i = 0; i < 60 && interrupt_out_n !== v; i++)
			tick(1);
	end
	endtask : wait_irq

	task automatic wait_ready;
	begin
		for (int i = 0; i < INIT_N + 20 && module_ready !== 1'b1; i++)
			tick(1);
	end
	endtask : wait_ready

	task automatic tally_and_finish;
	begin
		if (err_total == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_init;
	begin
		tick(16);
		rst_n = 1'b1;
		wait_ready();
		check(module_ready, 1, "ready after init");
		check(module_present_n, 0, "present");
		wait_irq(0);
		check(interrupt_out_n, 0, "init irq");
		i_host_master.xfer(REG_STATUS, 1, 0, rd, ack);
		check(ack, 1, "bus ack");
		check(rd, 8'h02, "status");
		wait_irq(1);
		check(interrupt_out_n, 1, "irq off after read");
	end
	endtask : test_init

	task automatic test_flags;
	begin
		cond_in.los[0] = 1'b1;
		wait_irq(0);
		check(interrupt_out_n, 0, "los irq");
		cond_in.los[0] = 1'b0;
		tick(5);
		i_host_master.xfer(REG_FLAGS, 1, 0, rd, ack);
		check(rd, 8'h01, "latched los");
		wait_irq(1);
		check(interrupt_out_n, 1, "los cleared");
		cond_in.fault[3] = 1'b1;
		wait_irq(0);
		check(interrupt_out_n, 0, "fault irq");
		i_host_master.xfer(REG_FLAGS, 1, 0, rd, ack);
		check(rd, 8'h80, "fault flag");
		cond_in.fault[3] = 1'b0;
		wait_irq(1);
		check(interrupt_out_n, 1, "fault cleared");
	end
	endtask : test_flags

	task automatic test_mask;
	begin
		i_host_master.xfer(REG_MASK, 0, 8'h02, rd, ack);
		cond_in.los[1] = 1'b1;
		tick(60);
		check(interrupt_out_n, 1, "masked");
		i_host_master.xfer(REG_MASK, 0, 8'h00, rd, ack);
		wait_irq(0);
		check(interrupt_out_n, 0, "unmasked");
		cond_in.los[1] = 1'b0;
		i_host_master.xfer(REG_FLAGS, 1, 0, rd, ack);
		check(rd, 8'h02, "masked flag kept");
		wait_irq(1);
		check(interrupt_out_n, 1, "unmasked flag cleared");
	end
	endtask : test_mask

	task automatic test_select;
	begin
		module_select_n = 1'b1;
		tick(10);
		i_host_master.xfer(REG_ID, 1, 0, rd, ack);
		check(ack, 0, "deselected");
		module_select_n = 1'b0;
		tick(10);
		i_host_master.xfer(REG_ID, 1, 0, rd, ack);
		check(ack, 1, "selected");
	end
	endtask : test_select

	task automatic test_power;
	begin
		low_power_request = 1'b1;
		tick(10);
		check(low_power_active, 1, "lp pin");
		low_power_request = 1'b0;
		i_host_master.xfer(REG_CTRL, 0, 8'h02, rd, ack);
		tick(10);
		check(low_power_active, 1, "pdown bit");
		i_host_master.xfer(REG_CTRL, 0, 8'h00, rd, ack);
		tick(10);
		check(low_power_active, 0, "pdown cleared");
		check(laser_enable, 0, "tx disabled");
		transmit_disable_in = 1'b0;
		tick(10);
		check(laser_enable, 1, "tx enabled");
	end
	endtask : test_power

	task automatic test_reset;
	begin
		module_reset_n = 1'b0;
		tick(40);
		module_reset_n = 1'b1;
		tick(10);
		check(module_ready, 1, "short pulse ignored");
		module_reset_n = 1'b0;
		tick(100);
		check(module_ready, 0, "long pulse resets");
		module_reset_n = 1'b1;
		wait_ready();
		check(module_ready, 1, "ready again");
		wait_irq(0);
		check(interrupt_out_n, 0, "init irq again");
	end
	endtask : test_reset

	initial
	begin
		test_init();
		test_flags();
		test_mask();
		test_select();
		test_power();
		test_reset();
		tally_and_finish();
	end

	// Whole run needs well under 20000 cycles
	initial
	begin
		repeat (40000) @(posedge sys_clk);
		err_total++;
		tally_and_finish();
	end
endmodule : module_mgmt_control_timing_tb
